// >>> core/sbs_ram.sv
// RAM end: synchronous burst static RAM control and storage
// Behaviour
// RULE1: Clock gate high freezes all internal state
// RULE2: Inputs sampled at edge; some act unclocked
// RULE3: Master starts every access with load
// RULE4: Selected only when all three selects active
// RULE5: Read begins and latches address on edge
// RULE6: Pipelined read data driven one edge later
// RULE7: Write taken when selected, enabled, write low
// RULE8: Only lanes with enable low are stored
// RULE9: Write with no lanes enabled is no-op
// RULE10: Each enable covers one nine-bit lane
// RULE11: Pipelined write data two edges after command
// RULE12: Flow-through read data right after address
// RULE13: Flow-through write data one edge after
// RULE14: Activation and counter same in both modes
// RULE15: Flow mode input low selects flow-through
// RULE16: Order select linear low; sleep high sleeps
// RULE17: Low address bits preset burst counter
// RULE18: Advance high steps counter, continues access
// RULE19: Counter wraps after four; linear or interleaved
// RULE20: Gated read keeps driving; gated write stays off
// RULE21: Output enable high or write data: drivers off
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
module sbs_ram
  import sbs_pkg::*;
#(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANE_W = `SBS_LANE_W,
  parameter int LANES = `SBS_LANES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Link
  sbs_if.ram bus,
  // Status
  output logic asleep_o,
  output logic [ADDR_W-1:0] cur_addr_o
);
  localparam int BW = `SBS_BURST_W;
  localparam int DEPTH = 1 << ADDR_W;
  // Word read from storage; the lanes drive disjoint slices of it
  wire [LANES*LANE_W-1:0] rd_word;
  logic selected;
  logic clk_on;
  sbs_cmd_type cmd;
  sbs_cmd_type last_cmd_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [BW-1:0] start_reg;
  logic [BW-1:0] step_reg;
  logic [BW-1:0] low_bits;
  logic [ADDR_W-1:0] acc_addr;
  logic [BW-1:0] step_next;
  // Command stages: index 0 = just registered, 1 = one edge older
  sbs_cmd_type st_cmd_reg [2];
  logic [ADDR_W-1:0] st_addr_reg [2];
  logic [LANES-1:0] st_we_n_reg [2];
  logic [LANES*LANE_W-1:0] q_reg;
  logic q_live_reg;
  logic pipe_mode;
  logic [LANES-1:0] wr_we_n;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_now;
  logic rd_drive;

  // ==========================================================
  // Command decode
  // Sleep stops every edge as well as floating the data drivers
  assign pipe_mode = bus.flow_mode_n; // RULE15
  assign clk_on = !bus.clk_en_n && !bus.sleep_request; // RULE1 RULE16
  assign selected = !bus.chip_sel_one_n && bus.chip_sel_two
    && !bus.chip_sel_three_n; // RULE4
  // A continue cycle repeats the last command, even a deselect
  always_comb
  begin
    if (bus.advance_load)
      cmd = last_cmd_reg; // RULE18
    else if (!selected)
      cmd = SBS_DESEL;
    else if (bus.write_n)
      cmd = SBS_READ; // RULE5
    else
      cmd = SBS_WRITE; // RULE7
  end

  // ==========================================================
  // Burst address: linear adds, interleaved XORs the step
  // The step count restarts on every load so a burst always
  // begins at the loaded offset
  assign step_next = bus.advance_load ? step_reg + `SBS_BURST_ONE
    : '0; // RULE18 RULE19
  assign low_bits = bus.advance_load ?
    (bus.linear_order_n ? start_reg ^ step_next
     : start_reg + step_next) : bus.addr[BW-1:0]; // RULE16 RULE19 RULE17
  assign acc_addr = bus.advance_load ?
    {base_reg[ADDR_W-1:BW], low_bits} : bus.addr;

  // Burst base and command state, one counter for both modes
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      base_reg <= '0;
      start_reg <= '0;
      step_reg <= '0;
      last_cmd_reg <= SBS_DESEL;
    end
    else if (clk_on) // RULE1 RULE2 RULE14
    begin
      step_reg <= step_next;
      last_cmd_reg <= cmd;
      if (!bus.advance_load)
      begin
        base_reg <= bus.addr; // RULE5
        start_reg <= bus.addr[BW-1:0]; // RULE17
      end
    end
  end

  // ==========================================================
  // Command stages for late write and read return
  // Stage 1 serves only the pipelined write, which lands two
  // edges after its command
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < 2; i++)
      begin
        st_cmd_reg[i] <= SBS_DESEL;
        st_addr_reg[i] <= '0;
        st_we_n_reg[i] <= '1;
      end
    end
    else if (clk_on) // RULE1
    begin
      st_cmd_reg[0] <= cmd;
      st_addr_reg[0] <= acc_addr;
      st_we_n_reg[0] <= bus.byte_we_n;
      st_cmd_reg[1] <= st_cmd_reg[0];
      st_addr_reg[1] <= st_addr_reg[0];
      st_we_n_reg[1] <= st_we_n_reg[0];
    end
  end

  // Write data arrives one edge (flow) or two edges (pipe) later
  assign wr_now = pipe_mode ? (st_cmd_reg[1] == SBS_WRITE)
    : (st_cmd_reg[0] == SBS_WRITE);
  assign wr_addr = pipe_mode ? st_addr_reg[1] : st_addr_reg[0];
  assign wr_we_n = pipe_mode ? st_we_n_reg[1] : st_we_n_reg[0];

  // ==========================================================
  // Storage, one lane per byte enable. Each lane owns its own
  // array, so no two processes ever write the same variable.
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [LANE_W-1:0] lane_mem [DEPTH];
      always_ff @(posedge core_clk_i)
      begin
        // All enables high leaves the word untouched
        if (clk_on && wr_now && !wr_we_n[g]) // RULE8 RULE9 RULE10
          lane_mem[wr_addr] <= bus.dq_m2s[g*LANE_W +: LANE_W];
      end
      // Read side sees the whole word at the registered address
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[st_addr_reg[0]];
    end
  endgenerate

  // ==========================================================
  // Output register; holds and keeps driving while gated
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q_reg <= '0;
      q_live_reg <= 1'b0;
    end
    else if (clk_on)
    begin
      q_reg <= rd_word; // RULE6
      q_live_reg <= st_cmd_reg[0] == SBS_READ;
    end
  end

  // A stalled read keeps its driver on, since q_live_reg is
  // frozen with the rest of the state
  // Flow-through reads bypass the output register
  assign rd_drive = pipe_mode ? q_live_reg
    : (st_cmd_reg[0] == SBS_READ); // RULE12 RULE20
  assign bus.dq_s2m = pipe_mode ? q_reg : rd_word; // RULE6
  // Output enable overrides without the clock; sleep also floats
  assign bus.dq_s2m_oe = rd_drive && !bus.out_en_n
    && !bus.sleep_request && !wr_now; // RULE21 RULE2 RULE20

  // ==========================================================
  // Status
  // Memory contents are not reset; only control state is
  assign asleep_o = bus.sleep_request;
  assign cur_addr_o = st_addr_reg[0];
endmodule : sbs_ram
`default_nettype wire

// >>> core/sbs_regs.svh
// Constants for the synchronous burst static RAM link and core
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_ADDR_W 8
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_BURST_W 2
`define SBS_BURST_ONE 2'h1
`define SBS_LAT_PIPE 2
`define SBS_LAT_FLOW 1
`endif

// >>> core/sbs_pkg.sv
// Package holding the command types of the burst static RAM block
`include "sbs_regs.svh"
package sbs_pkg;
  typedef enum logic [1:0] {SBS_DESEL, SBS_READ, SBS_WRITE} sbs_cmd_type;
endpackage : sbs_pkg

// >>> core/sbs_if.sv
// Interface joining the master to the burst static RAM
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
interface sbs_if;
  logic [`SBS_ADDR_W-1:0] addr;
  logic chip_sel_one_n;
  logic chip_sel_two;
  logic chip_sel_three_n;
  logic write_n;
  logic [`SBS_LANES-1:0] byte_we_n;
  logic advance_load;
  logic clk_en_n;
  logic out_en_n;
  logic flow_mode_n;
  logic linear_order_n;
  logic sleep_request;
  logic [`SBS_LANES*`SBS_LANE_W-1:0] dq_m2s;
  logic dq_m2s_oe;
  logic [`SBS_LANES*`SBS_LANE_W-1:0] dq_s2m;
  logic dq_s2m_oe;
  modport ram (input addr, chip_sel_one_n, chip_sel_two, chip_sel_three_n,
    write_n, byte_we_n, advance_load, clk_en_n, out_en_n, flow_mode_n,
    linear_order_n, sleep_request, dq_m2s, dq_m2s_oe,
    output dq_s2m, dq_s2m_oe);
  modport master (output addr, chip_sel_one_n, chip_sel_two,
    chip_sel_three_n, write_n, byte_we_n, advance_load, clk_en_n, out_en_n,
    flow_mode_n, linear_order_n, sleep_request, dq_m2s, dq_m2s_oe,
    input dq_s2m, dq_s2m_oe);
endinterface : sbs_if
`default_nettype wire

// >>> core/sbs_master.sv
// Bus master end: turns user requests into timed RAM bus commands
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
module sbs_master
  import sbs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Link
  sbs_if.master bus,
  // User request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_burst_i,
  input wire logic [`SBS_ADDR_W-1:0] req_addr_i,
  input wire logic [`SBS_LANES-1:0] req_byte_we_n_i,
  input wire logic [`SBS_LANES*`SBS_LANE_W-1:0] req_wdata_i,
  input wire logic stall_i,
  input wire logic out_en_n_i,
  input wire logic flow_mode_n_i,
  input wire logic linear_order_n_i,
  input wire logic sleep_request_i,
  // User answer
  output logic rd_valid_o,
  output logic [`SBS_LANES*`SBS_LANE_W-1:0] rd_data_o
);
  localparam int LAT = `SBS_LAT_PIPE;
  logic [LAT:0] wr_pipe_reg;
  logic [LAT:0] rd_pipe_reg;
  logic [`SBS_LANES*`SBS_LANE_W-1:0] wd_pipe_reg [LAT:0];
  logic [LAT:0] wr_pipe_next;
  logic [LAT:0] rd_pipe_next;
  logic take;
  logic hold;
  logic [1:0] dly;

  // ==========================================================
  // Command drive
  assign take = req_valid_i && !stall_i && !sleep_request_i;
  // Sleep freezes the RAM as well, so queued slots must wait too
  assign hold = stall_i || sleep_request_i;
  assign dly = flow_mode_n_i ? 2'(`SBS_LAT_PIPE) : 2'(`SBS_LAT_FLOW);
  assign bus.addr = req_addr_i;
  assign bus.chip_sel_one_n = !take;
  assign bus.chip_sel_two = take;
  assign bus.chip_sel_three_n = !take;
  assign bus.write_n = !req_write_i;
  assign bus.byte_we_n = req_byte_we_n_i;
  // A new access loads its address; only bursts advance
  assign bus.advance_load = take && req_burst_i; // RULE3
  assign bus.clk_en_n = stall_i;
  assign bus.out_en_n = out_en_n_i;
  assign bus.flow_mode_n = flow_mode_n_i;
  assign bus.linear_order_n = linear_order_n_i;
  assign bus.sleep_request = sleep_request_i;

  // ==========================================================
  // Delay lines for write data and read return
  always_comb
  begin
    wr_pipe_next = {wr_pipe_reg[LAT-1:0], 1'b0};
    rd_pipe_next = {rd_pipe_reg[LAT-1:0], 1'b0};
    wr_pipe_next[0] = take && req_write_i;
    rd_pipe_next[0] = take && !req_write_i;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_pipe_reg <= '0;
      rd_pipe_reg <= '0;
    end
    else if (!hold)
    begin
      wr_pipe_reg <= wr_pipe_next;
      rd_pipe_reg <= rd_pipe_next;
    end
  end

  // Data follows its command; stall freezes it like the RAM
  always_ff @(posedge core_clk_i)
  begin
    if (!hold)
    begin
      wd_pipe_reg[0] <= req_wdata_i;
      for (int i = 1; i <= LAT; i++)
        wd_pipe_reg[i] <= wd_pipe_reg[i-1];
    end
  end

  // Write data one or two edges after the command
  assign bus.dq_m2s_oe = wr_pipe_reg[dly-1]; // RULE11 RULE13
  assign bus.dq_m2s = wd_pipe_reg[dly-1];

  // ==========================================================
  // Read capture from the bus
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end
    else
    begin
      rd_valid_o <= !hold && rd_pipe_reg[dly-1];
      if (!hold && rd_pipe_reg[dly-1])
        rd_data_o <= bus.dq_s2m;
    end
  end
endmodule : sbs_master
`default_nettype wire

// >>> bench/sbs_link_sva.sv
// Assertions on the link between the master and RAM ends
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
module sbs_link_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Link controls
  input wire logic chip_sel_one_n,
  input wire logic chip_sel_two,
  input wire logic chip_sel_three_n,
  input wire logic write_n,
  input wire logic [`SBS_LANES-1:0] byte_we_n,
  input wire logic advance_load,
  input wire logic clk_en_n,
  input wire logic out_en_n,
  input wire logic flow_mode_n,
  input wire logic sleep_request,
  // Link data
  input wire logic dq_m2s_oe,
  input wire logic [`SBS_LANES*`SBS_LANE_W-1:0] dq_s2m,
  input wire logic dq_s2m_oe
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ======
  // Command decode at a live edge
  logic live, sel, rd, wr, quiet;
  assign live = !clk_en_n && !sleep_request;
  assign sel = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
  assign rd = live && !advance_load && sel && write_n && !out_en_n;
  assign wr = live && !advance_load && sel && !write_n && byte_we_n != 4'hF;
  assign quiet = out_en_n || sleep_request;
  // ======
  // Data timing and driver rules
  pipe_rd_a: assert property (
    rd && flow_mode_n ##1 live |-> ##1 (dq_s2m_oe || quiet))
    else $error("pipe read data late");
  flow_rd_a: assert property (
    rd && !flow_mode_n |-> ##1 (dq_s2m_oe || quiet))
    else $error("flow read data late");
  desel_a: assert property (
    live && !advance_load && !sel && flow_mode_n ##1 live && flow_mode_n
    |-> ##1 !dq_s2m_oe) else $error("deselected ram drives");
  pipe_wr_a: assert property (
    wr && flow_mode_n ##1 live |-> ##1 dq_m2s_oe)
    else $error("pipe write data missing");
  flow_wr_a: assert property (
    wr && !flow_mode_n |-> ##1 dq_m2s_oe)
    else $error("flow write data missing");
  oe_off_a: assert property (out_en_n |-> !dq_s2m_oe)
    else $error("drivers on while disabled");
  sleep_off_a: assert property (sleep_request |-> !dq_s2m_oe)
    else $error("drivers on while asleep");
  no_fight_a: assert property (!(dq_s2m_oe && dq_m2s_oe))
    else $error("both ends drive data");
  stall_hold_a: assert property (
    $past(reset_n_i) && $past(clk_en_n) && $stable(quiet)
    |-> $stable(dq_s2m) && $stable(dq_s2m_oe)) else $error("stall moved data");
  // Main scenarios reached
  cov_pipe: cover property (rd && flow_mode_n);
  cov_flow: cover property (wr && !flow_mode_n);
  cov_stall: cover property (clk_en_n && dq_s2m_oe);
endmodule : sbs_link_sva
`default_nettype wire

// >>> bench/tb_sync_burst_sram_core.sv
// Self-checking bench joining the master and RAM ends
`timescale 1ns/10ps
`default_nettype none
`include "sbs_regs.svh"
module tb_sync_burst_sram_core;
  // ======
  // Stimulus and observed signals
  logic clk = 1'h0, rst_n = 1'h0, valid = 1'h0, wr = 1'h0, burst = 1'h0;
  logic stall = 1'h0, oe_n = 1'h0, flow_n = 1'h1, lin_n = 1'h0;
  logic sleep = 1'h0, rvalid, asleep;
  logic [7:0] addr = 8'h00, cur_addr;
  logic [3:0] be_n = 4'hF;
  logic [35:0] wdata = 36'h0, rdata;
  logic [35:0] rq[$];
  int fails = 0, checks = 0;
  sbs_if bus_if ();
  // Free-running core clock
  always #10 clk = !clk;
  // ======
  // Both ends and the checker
  sbs_master sbs_master_inst (.core_clk_i(clk), .reset_n_i(rst_n),
    .bus(bus_if), .req_valid_i(valid), .req_write_i(wr),
    .req_burst_i(burst), .req_addr_i(addr), .req_byte_we_n_i(be_n),
    .req_wdata_i(wdata), .stall_i(stall), .out_en_n_i(oe_n),
    .flow_mode_n_i(flow_n), .linear_order_n_i(lin_n),
    .sleep_request_i(sleep), .rd_valid_o(rvalid), .rd_data_o(rdata));
  sbs_ram sbs_ram_inst (.core_clk_i(clk), .reset_n_i(rst_n), .bus(bus_if),
    .asleep_o(asleep), .cur_addr_o(cur_addr));
  sbs_link_sva sbs_link_sva_inst (.core_clk_i(clk), .reset_n_i(rst_n),
    .chip_sel_one_n(bus_if.chip_sel_one_n),
    .chip_sel_two(bus_if.chip_sel_two),
    .chip_sel_three_n(bus_if.chip_sel_three_n), .write_n(bus_if.write_n),
    .byte_we_n(bus_if.byte_we_n), .advance_load(bus_if.advance_load),
    .clk_en_n(bus_if.clk_en_n), .out_en_n(bus_if.out_en_n),
    .flow_mode_n(bus_if.flow_mode_n), .sleep_request(bus_if.sleep_request),
    .dq_m2s_oe(bus_if.dq_m2s_oe), .dq_s2m(bus_if.dq_s2m),
    .dq_s2m_oe(bus_if.dq_s2m_oe));
  // Read answers queue up so back-to-back reads are never lost
  always @(posedge clk) if (rvalid === 1'h1) rq.push_back(rdata);
  // ======
  // Shared tasks
  task automatic check(input string nm, input logic [35:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic issue(input logic w, b, input logic [7:0] a,
    input logic [3:0] m, input logic [35:0] d);
    @(negedge clk);
    {valid, wr, burst, addr, be_n, wdata} = {1'h1, w, b, a, m, d};
  endtask : issue
  task automatic idle(input int n);
    @(negedge clk);
    valid = 1'h0;
    repeat (n) @(negedge clk);
  endtask : idle
  // Bounded wait; a missing answer counts as a mismatch
  task automatic expect_rd(input string nm, input logic [35:0] exp);
    logic [35:0] d;
    for (int i = 0; i < 40 && rq.size() == 0; i++) @(posedge clk);
    d = (rq.size() != 0) ? rq.pop_front() : ~exp;
    check(nm, d, exp);
  endtask : expect_rd
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // ======
  // Scenarios
  task automatic sc_pipe_write;
    issue(1'h1, 1'h0, 8'h10, 4'h0, 36'h123456789);
    issue(1'h1, 1'h0, 8'h11, 4'h0, 36'hFFFFFFFFF);
    issue(1'h1, 1'h0, 8'h11, 4'hD, 36'h000000000);
    issue(1'h1, 1'h0, 8'h10, 4'hF, 36'h000000000);
    issue(1'h0, 1'h0, 8'h10, 4'hF, 36'h0);
    issue(1'h0, 1'h0, 8'h11, 4'hF, 36'h0);
    idle(2);
    expect_rd("full", 36'h123456789);
    expect_rd("lane_b", 36'hFFFFC01FF);
  endtask : sc_pipe_write
  task automatic sc_flow;
    @(negedge clk);
    flow_n = 1'h0;
    idle(2);
    issue(1'h1, 1'h0, 8'h20, 4'h0, 36'h0A5A5A5A5);
    issue(1'h0, 1'h0, 8'h20, 4'hF, 36'h0);
    idle(2);
    expect_rd("flow", 36'h0A5A5A5A5);
    @(negedge clk);
    flow_n = 1'h1;
    idle(2);
  endtask : sc_flow
  // Linear from offset 2, then interleaved from offset 1
  task automatic sc_burst;
    logic [1:0] s;
    for (int i = 0; i < 4; i++)
      issue(1'h1, 1'h0, 8'h30 + 8'(i), 4'h0, 36'hA00 + 36'(i));
    idle(3);
    for (int o = 0; o < 2; o++)
    begin
      @(negedge clk);
      lin_n = o[0];
      for (int k = 0; k < 4; k++)
        issue(1'h0, k != 0, 8'h32 - 8'(o), 4'hF, 36'h0);
      idle(3);
      for (int k = 0; k < 4; k++)
      begin
        s = o ? 2'h1 ^ 2'(k) : 2'h2 + 2'(k);
        expect_rd("burst", 36'hA00 + 36'(s));
      end
    end
  endtask : sc_burst
  // Stall with read data out, then gate it by enable and sleep
  task automatic sc_stall;
    issue(1'h0, 1'h0, 8'h10, 4'hF, 36'h0);
    idle(0);
    @(negedge clk);
    stall = 1'h1;
    repeat (3) @(negedge clk);
    check("held", bus_if.dq_s2m, 36'h123456789);
    check("held_oe", bus_if.dq_s2m_oe, 36'h1);
    check("cur_addr", cur_addr, 36'h10);
    check("no_answer", 36'(rq.size()), 36'h0);
    oe_n = 1'h1;
    #1 check("oe_off", bus_if.dq_s2m_oe, 36'h0);
    @(negedge clk);
    oe_n = 1'h0;
    sleep = 1'h1;
    #1 check("asleep", asleep, 36'h1);
    check("sleep_off", bus_if.dq_s2m_oe, 36'h0);
    @(negedge clk);
    sleep = 1'h0;
    @(negedge clk);
    stall = 1'h0;
    expect_rd("stall", 36'h123456789);
  endtask : sc_stall
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    sc_pipe_write();
    sc_flow();
    sc_burst();
    sc_stall();
    complete_run();
  end
  // Watchdog well beyond the seventy or so cycles the scenarios need
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule : tb_sync_burst_sram_core
`default_nettype wire
